// ==== verilog/rt_output_regs.svh ====
// register addresses, field positions and reset values of the triggered pattern output port
`ifndef RT_OUTPUT_REGS_SVH
`define RT_OUTPUT_REGS_SVH

// special function register addresses, each byte-wide
`define ADDR_CONTROL      8'h00
`define ADDR_BUF_HIGH     8'h01
`define ADDR_BUF_LOW      8'h02
`define ADDR_PORT_LATCH   8'h03
`define ADDR_PORT_DIR     8'h04

// pattern_output_control field positions
`define CTL_LOW_EN        0
`define CTL_HIGH_EN       1
`define CTL_BYTE          2
`define CTL_EXT_EN        3
`define CTL_EXT_ONLY      4
`define CTRL_MASK         8'h1F

// nibble field bounds
`define HI_MSB            7
`define HI_LSB            4
`define LO_MSB            3
`define LO_LSB            0
`define NIBBLE_ONES       4'hF

// reset values
`define CTRL_RESET        8'h00
`define BUF_RESET         4'h0
`define LATCH_RESET       8'h00
`define DIR_RESET         8'hFF
`define OE_RESET          8'h00
`define RD_IDLE           8'h00
`define SYNC_RESET        1'b0

`endif

// ==== verilog/rt_output_pkg.sv ====
// types shared by the triggered pattern output port
package rt_output_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [3:0] nibble_t;
    typedef logic [7:0] sfr_addr_t;
    typedef logic [2:0] bit_sel_t;

    // which source fires the low nibble (or the whole byte in 8-bit mode)
    typedef enum logic [1:0]
    {
        SRC_COMPARE,
        SRC_COMPARE_OR_EXT,
        SRC_EXT_ONLY
    } trig_src_t;

endpackage

// ==== verilog/rt_trig_if.sv ====
// control bits in, trigger pulses out, between the port core and the trigger selector
`timescale 1ns/10ps

interface rt_trig_if;
    logic lowEn;
    logic highEn;
    logic byteSel;
    logic extEn;
    logic extOnly;
    logic cmp0;
    logic cmp1;
    logic extEvent;
    logic trigLow;
    logic trigHigh;

    modport sel
    (
        input  lowEn,
        input  highEn,
        input  byteSel,
        input  extEn,
        input  extOnly,
        input  cmp0,
        input  cmp1,
        input  extEvent,
        output trigLow,
        output trigHigh
    );

    modport core
    (
        output lowEn,
        output highEn,
        output byteSel,
        output extEn,
        output extOnly,
        output cmp0,
        output cmp1,
        output extEvent,
        input  trigLow,
        input  trigHigh
    );
endinterface

// ==== verilog/rt_trigger_select.sv ====
// trigger source selection for the two nibbles of the pattern output port
`timescale 1ns/10ps

module rt_trigger_select
(
    input  logic           clk_sys,
    input  logic           nrst,
    rt_trig_if.sel         trg
);
    import rt_output_pkg::*;

    // external-enable / external-only pair to a source; ext-only without ext-enable counts as compare
    function automatic trig_src_t srcOf(input logic extEn, input logic extOnly);
        trig_src_t s;
        s = SRC_COMPARE;
        unique case ({extEn, extOnly})
            2'b10:   s = SRC_COMPARE_OR_EXT;
            2'b11:   s = SRC_EXT_ONLY;
            default: s = SRC_COMPARE;
        endcase
        return s;
    endfunction

    wire trig_src_t src;
    wire logic      byteMode;
    wire logic      lowSource;

    // byte mode only counts when both nibbles are real-time
    assign src       = srcOf(trg.extEn, trg.extOnly);
    assign byteMode  = trg.byteSel & trg.lowEn & trg.highEn;
    assign lowSource = (src == SRC_EXT_ONLY)       ? trg.extEvent :
                       (src == SRC_COMPARE_OR_EXT) ? (trg.cmp0 | trg.extEvent) :
                                                     trg.cmp0;

    // high nibble follows compare 1 alone unless the byte moves as one
    assign trg.trigLow  = trg.lowEn & lowSource;
    assign trg.trigHigh = trg.highEn & (byteMode ? lowSource : trg.cmp1);

    a_high_cmp_one: assert property (@(posedge clk_sys) disable iff (!nrst)
        (trg.highEn && !byteMode) |-> (trg.trigHigh == trg.cmp1))
        else $error("high nibble trigger is not compare 1 in 4-bit mode");

    a_byte_both_fire: assert property (@(posedge clk_sys) disable iff (!nrst)
        byteMode |-> (trg.trigHigh == trg.trigLow))
        else $error("8-bit mode nibbles triggered apart");

    a_ext_only_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (trg.lowEn && trg.extEn && trg.extOnly) |-> (trg.trigLow == trg.extEvent))
        else $error("external-only low trigger mismatch");

    a_cmp_only_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (trg.lowEn && !trg.extEn) |-> (trg.trigLow == trg.cmp0))
        else $error("compare-only low trigger mismatch");
endmodule

// ==== verilog/triggered_pattern_output_port.sv ====
// eight-pin output port whose latch is reloaded from staging buffers on timer or external triggers
//
// Functional notes
// - a selected trigger copies the staged nibble into the output latch by hardware
// - two independent 4-bit channels, or one 8-bit channel over all pins
// - 8-bit control register, byte and bit access, cleared to zero by reset
// - real-time enable turns the nibble's drivers on whatever the direction register says
// - high and low staging buffers sit at separate addresses, written independently outside 8-bit mode
// - in 4-bit mode a write to one buffer leaves the other unchanged
// - in 8-bit mode a byte write to either buffer loads both nibbles
// - reading either buffer address returns high buffer over low buffer
// - outside 8-bit mode each buffer address writes only its own nibble
// - port reads return the latch; writes change only ordinary port nibbles
// - 4-bit mode: high on compare 1; low on compare 0, external pin, or both
// - 8-bit mode: whole byte on compare 0, external pin, or both
// - trigger selection table applies with both nibble enables set
// - compare-match triggers space output changes by the programmed compare interval
// - an external-pin trigger updates the output in step with that event
// - software cannot write a real-time nibble of the latch
`timescale 1ns/10ps
`include "rt_output_regs.svh"

module triggered_pattern_output_port
(
    input  logic                     clk_sys,
    input  logic                     nrst,
    input  rt_output_pkg::sfr_addr_t sfrAddr,
    input  logic                     sfrWr,
    input  logic                     sfrBitWr,
    input  rt_output_pkg::bit_sel_t  sfrBitSel,
    input  logic                     sfrBitVal,
    input  rt_output_pkg::byte_t     sfrWdata,
    input  logic                     sfrRd,
    output rt_output_pkg::byte_t     sfrRdata,
    input  logic                     compare0MatchEvent,
    input  logic                     compare1MatchEvent,
    input  logic                     externalTriggerPin,
    output rt_output_pkg::byte_t     portOut,
    output rt_output_pkg::byte_t     portOe
);
    import rt_output_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // replace one bit of a byte; bit access is a read-modify-write of the whole register
    function automatic byte_t mergeBit(input byte_t cur, input bit_sel_t sel, input logic val);
        byte_t r;
        r = cur;
        r[sel] = val;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    byte_t   ctrl;          // pattern_output_control
    nibble_t bufHigh;       // pattern_buffer_high
    nibble_t bufLow;        // pattern_buffer_low
    byte_t   latch;         // port_latch_register
    byte_t   dirReg;        // port_direction_register, 1 = input
    logic    extMeta;
    logic    extSync;
    logic    extPrev;

    ////////////////////////////////////////////////////////////////////////////////
    // control decode

    wire logic lowEn;
    wire logic highEn;
    wire logic rt8;

    assign lowEn  = ctrl[`CTL_LOW_EN];
    assign highEn = ctrl[`CTL_HIGH_EN];
    assign rt8    = ctrl[`CTL_BYTE] & lowEn & highEn;

    ////////////////////////////////////////////////////////////////////////////////
    // register access decode

    wire logic  selCtrl;
    wire logic  selHigh;
    wire logic  selLow;
    wire logic  selPort;
    wire logic  selDir;
    wire byte_t addrValue;
    wire logic  wrAny;
    wire byte_t wrByte;

    // the staging buffers answer at two distinct addresses
    assign selCtrl = (sfrAddr == `ADDR_CONTROL);
    assign selHigh = (sfrAddr == `ADDR_BUF_HIGH);
    assign selLow  = (sfrAddr == `ADDR_BUF_LOW);
    assign selPort = (sfrAddr == `ADDR_PORT_LATCH);
    assign selDir  = (sfrAddr == `ADDR_PORT_DIR);

    // one read mux serves both reads and bit writes; unmapped addresses read as zero
    assign addrValue = selCtrl             ? ctrl :
                       (selHigh | selLow)  ? {bufHigh, bufLow} :
                       selPort             ? latch :
                       selDir              ? dirReg :
                                             `RD_IDLE;

    // byte write wins if both strobes arrive together
    assign wrAny  = sfrWr | sfrBitWr;
    assign wrByte = sfrWr ? sfrWdata : mergeBit(addrValue, sfrBitSel, sfrBitVal);

    ////////////////////////////////////////////////////////////////////////////////
    // external trigger pin synchroniser and edge detect

    // rising edge chosen; edge detector reads only the second and third stages
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            extMeta <= `SYNC_RESET;
            extSync <= `SYNC_RESET;
            extPrev <= `SYNC_RESET;
        end
        else
        begin
            extMeta <= externalTriggerPin;
            extSync <= extMeta;
            extPrev <= extSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trigger selection

    rt_trig_if trg ();

    assign trg.lowEn    = lowEn;
    assign trg.highEn   = highEn;
    assign trg.byteSel  = ctrl[`CTL_BYTE];
    assign trg.extEn    = ctrl[`CTL_EXT_EN];
    assign trg.extOnly  = ctrl[`CTL_EXT_ONLY];
    assign trg.cmp0     = compare0MatchEvent; // timer sits on clk_sys, so no synchroniser
    assign trg.cmp1     = compare1MatchEvent;
    assign trg.extEvent = extSync & ~extPrev;

    rt_trigger_select u_select
    (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .trg     (trg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next values

    wire logic    loadHigh;
    wire logic    loadLow;
    wire logic    wrPort;
    wire nibble_t next_bufHigh;
    wire nibble_t next_bufLow;
    wire nibble_t next_latchHigh;
    wire nibble_t next_latchLow;
    wire byte_t   next_oe;

    // 8-bit mode: either buffer address loads both nibbles at once
    assign loadHigh     = wrAny & (selHigh | (rt8 & selLow));
    assign loadLow      = wrAny & (selLow | (rt8 & selHigh));
    assign next_bufHigh = loadHigh ? wrByte[`HI_MSB:`HI_LSB] : bufHigh;
    assign next_bufLow  = loadLow ? wrByte[`LO_MSB:`LO_LSB] : bufLow;

    // trigger copies the buffer as it stood before this edge; software is shut out of real-time nibbles
    assign wrPort         = wrAny & selPort;
    assign next_latchHigh = trg.trigHigh          ? bufHigh :
                            (wrPort & ~highEn)    ? wrByte[`HI_MSB:`HI_LSB] :
                                                    latch[`HI_MSB:`HI_LSB];
    assign next_latchLow  = trg.trigLow           ? bufLow :
                            (wrPort & ~lowEn)     ? wrByte[`LO_MSB:`LO_LSB] :
                                                    latch[`LO_MSB:`LO_LSB];

    // enabling real-time output drives the latch straight out, so load the latch first
    assign next_oe = {{4{highEn}}, {4{lowEn}}} | ~dirReg;

    ////////////////////////////////////////////////////////////////////////////////
    // control and direction registers

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl   <= `CTRL_RESET;
            dirReg <= `DIR_RESET;
        end
        else
        begin
            ctrl   <= (wrAny & selCtrl) ? (wrByte & `CTRL_MASK) : ctrl;
            dirReg <= (wrAny & selDir) ? wrByte : dirReg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // staging buffers and output latch

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bufHigh <= `BUF_RESET;
            bufLow  <= `BUF_RESET;
            latch   <= `LATCH_RESET;
        end
        else
        begin
            bufHigh <= next_bufHigh;
            bufLow  <= next_bufLow;
            latch   <= {next_latchHigh, next_latchLow};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive and read data

    // enables are registered, so they follow a control write by one cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            portOe   <= `OE_RESET;
            sfrRdata <= `RD_IDLE;
        end
        else
        begin
            portOe   <= next_oe;
            sfrRdata <= sfrRd ? addrValue : `RD_IDLE; // reads have no side effects
        end
    end

    assign portOut = latch; // latch is a flip-flop, the pins see it directly

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_lowEnHeld;
        lowEn [*2];
    endsequence

    sequence s_highEnHeld;
        highEn [*2];
    endsequence

    sequence s_portWriteHighRt;
        wrPort && highEn && !trg.trigHigh;
    endsequence

    a_high_trig_load: assert property (trg.trigHigh |=> latch[`HI_MSB:`HI_LSB] == $past(bufHigh))
        else $error("high nibble not loaded from buffer after trigger");

    a_low_trig_load: assert property (trg.trigLow |=> latch[`LO_MSB:`LO_LSB] == $past(bufLow))
        else $error("low nibble not loaded from buffer after trigger");

    a_low_rt_drive: assert property (s_lowEnHeld |-> portOe[`LO_MSB:`LO_LSB] == `NIBBLE_ONES)
        else $error("low nibble drivers off in real-time mode");

    a_high_rt_drive: assert property (s_highEnHeld |-> portOe[`HI_MSB:`HI_LSB] == `NIBBLE_ONES)
        else $error("high nibble drivers off in real-time mode");

    a_rt_write_block: assert property (s_portWriteHighRt |=> $stable(latch[`HI_MSB:`HI_LSB]))
        else $error("software altered a real-time nibble of the latch");

    a_plain_port_write: assert property (sfrWr && selPort && !lowEn |=>
        latch[`LO_MSB:`LO_LSB] == $past(sfrWdata[`LO_MSB:`LO_LSB]))
        else $error("ordinary port nibble not written");

    a_buf_independent: assert property (wrAny && selHigh && !rt8 |=> $stable(bufLow))
        else $error("high buffer write disturbed low buffer");

    a_byte_split: assert property (sfrWr && (selHigh || selLow) && rt8 |=>
        {bufHigh, bufLow} == $past(sfrWdata))
        else $error("8-bit buffer write did not load both nibbles");

    a_buf_readback: assert property (sfrRd && (selHigh || selLow) |=> sfrRdata == $past({bufHigh, bufLow}))
        else $error("buffer read did not return high over low");

    a_ctrl_write: assert property (sfrWr && selCtrl |=> ctrl == ($past(sfrWdata) & `CTRL_MASK))
        else $error("control register write lost");

    // triggers and permitted port writes are the only ways the latch may move
    a_latch_hold: assert property (!trg.trigHigh && !trg.trigLow && !wrPort |=> $stable(latch))
        else $error("latch moved without a trigger or port write");

    a_low_rt_block: assert property (wrPort && lowEn && !trg.trigLow |=> $stable(latch[`LO_MSB:`LO_LSB]))
        else $error("software altered the real-time low nibble");

    a_both_same_edge: assert property (trg.trigHigh && trg.trigLow |=> latch == $past({bufHigh, bufLow}))
        else $error("coincident triggers did not load both nibbles");

    a_dir_plain_oe: assert property (!lowEn && !highEn |=> portOe == ~$past(dirReg))
        else $error("port mode drivers do not follow direction register");

    a_read_idle: assert property (!sfrRd |=> sfrRdata == `RD_IDLE)
        else $error("read data not idle without a read strobe");
endmodule

// ==== tb/step_driver_model.sv ====
// off-chip stepping driver model: latches driven pins and raises the external trigger pin on request
`timescale 1ns/10ps

module step_driver_model
(
    input  logic                 clk_sys,
    input  rt_output_pkg::byte_t pins,
    input  rt_output_pkg::byte_t pinsOe,
    input  logic                 extReq,
    output logic                 externalTriggerPin,
    output rt_output_pkg::byte_t seen
);
    import rt_output_pkg::*;

    logic [2:0] holdCount;

    initial
    begin
        externalTriggerPin = 1'b0;
        holdCount = 3'h0;
        seen = 8'h00;
    end

    // sensor edge held several cycles so the two-flop synchroniser cannot miss it
    always @(posedge clk_sys)
    begin
        holdCount <= extReq ? 3'h4 : (holdCount != 3'h0 ? holdCount - 3'h1 : 3'h0);
        externalTriggerPin <= extReq || (holdCount > 3'h1);
    end

    // driver inputs keep their own level when the port stops driving them
    always @(posedge clk_sys)
    begin
        seen <= (pins & pinsOe) | (seen & ~pinsOe);
    end
endmodule

// ==== tb/triggered_pattern_output_port_tb.sv ====
// self-checking bench for the triggered pattern output port
`timescale 1ns/10ps
`include "rt_output_regs.svh"

module triggered_pattern_output_port_tb;
    import rt_output_pkg::*;

    logic      clk_sys;
    logic      nrst;
    sfr_addr_t sfrAddr;
    logic      sfrWr;
    logic      sfrBitWr;
    bit_sel_t  sfrBitSel;
    logic      sfrBitVal;
    byte_t     sfrWdata;
    logic      sfrRd;
    byte_t     sfrRdata;
    logic      cmp0;
    logic      cmp1;
    logic      extPin;
    logic      extReq;
    byte_t     portOut;
    byte_t     portOe;
    byte_t     seen;
    int        fails;
    int        compares;

    triggered_pattern_output_port dut
    (
        .clk_sys(clk_sys), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrBitWr(sfrBitWr),
        .sfrBitSel(sfrBitSel), .sfrBitVal(sfrBitVal), .sfrWdata(sfrWdata), .sfrRd(sfrRd),
        .sfrRdata(sfrRdata), .compare0MatchEvent(cmp0), .compare1MatchEvent(cmp1),
        .externalTriggerPin(extPin), .portOut(portOut), .portOe(portOe)
    );

    step_driver_model partner
    (
        .clk_sys(clk_sys), .pins(portOut), .pinsOe(portOe), .extReq(extReq),
        .externalTriggerPin(extPin), .seen(seen)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 25 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared bus and compare helpers, all driven on the falling edge
    task chk(input byte_t got, input byte_t exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task wr(input sfr_addr_t a, input byte_t d);
        @(negedge clk_sys);
        sfrAddr = a;
        sfrWdata = d;
        sfrWr = 1'b1;
        @(negedge clk_sys);
        sfrWr = 1'b0;
    endtask

    task bitWr(input sfr_addr_t a, input bit_sel_t b, input logic v);
        @(negedge clk_sys);
        sfrAddr = a;
        sfrBitSel = b;
        sfrBitVal = v;
        sfrBitWr = 1'b1;
        @(negedge clk_sys);
        sfrBitWr = 1'b0;
    endtask

    // read data is registered, so it is valid one cycle after the strobe
    task rd(input sfr_addr_t a, input byte_t exp, input string what);
        @(negedge clk_sys);
        sfrAddr = a;
        sfrRd = 1'b1;
        @(negedge clk_sys);
        sfrRd = 1'b0;
        chk(sfrRdata, exp, what);
    endtask

    task pulse(input logic c0, input logic c1, input byte_t exp);
        @(negedge clk_sys);
        cmp0 = c0;
        cmp1 = c1;
        @(negedge clk_sys);
        cmp0 = 1'b0;
        cmp1 = 1'b0;
        chk(portOut, exp, "latch after compare pulse");
    endtask

    // pin edge passes a synchroniser, so allow a bounded number of cycles
    task extFire(input byte_t exp);
        int n;
        @(negedge clk_sys);
        extReq = 1'b1;
        @(negedge clk_sys);
        extReq = 1'b0;
        n = 0;
        while (portOut !== exp && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(portOut, exp, "latch after external trigger");
        if (portOut !== exp)
            summarize();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task testControl();
        rd(`ADDR_CONTROL, 8'h00, "control reset");
        chk(portOe, 8'h00, "enables after reset");
        bitWr(`ADDR_CONTROL, 3'h2, 1'b1);
        rd(`ADDR_CONTROL, 8'h04, "control bit write");
        wr(`ADDR_CONTROL, 8'hFF);
        rd(`ADDR_CONTROL, 8'h1F, "control byte write");
        wr(`ADDR_CONTROL, 8'h00);
        rd(8'h7E, 8'h00, "unmapped read");
        $display("test control done");
    endtask

    task testBuffers();
        wr(`ADDR_BUF_LOW, 8'h05);
        wr(`ADDR_BUF_HIGH, 8'hC0);
        rd(`ADDR_BUF_HIGH, 8'hC5, "high address read");
        rd(`ADDR_BUF_LOW, 8'hC5, "low address read");
        wr(`ADDR_BUF_LOW, 8'h0A);
        rd(`ADDR_BUF_HIGH, 8'hCA, "low write keeps high");
        rd(`ADDR_PORT_LATCH, 8'h00, "latch untouched by buffers");
        $display("test buffers done");
    endtask

    task testLatch();
        wr(`ADDR_PORT_LATCH, 8'h5A); // initialise before enabling
        rd(`ADDR_PORT_LATCH, 8'h5A, "port mode latch write");
        wr(`ADDR_PORT_DIR, 8'h00);
        @(negedge clk_sys); // enables are registered one cycle behind the write
        chk(portOe, 8'hFF, "direction drives all");
        wr(`ADDR_PORT_DIR, 8'hFF);
        wr(`ADDR_CONTROL, 8'h01);
        @(negedge clk_sys);
        chk(portOe, 8'h0F, "enable overrides direction");
        wr(`ADDR_PORT_LATCH, 8'h00);
        rd(`ADDR_PORT_LATCH, 8'h0A, "real-time nibble kept");
        $display("test latch done");
    endtask

    task testFourBit();
        wr(`ADDR_CONTROL, 8'h03);
        wr(`ADDR_BUF_LOW, 8'h05); // differs from the latch so a missed trigger shows
        pulse(1'b1, 1'b0, 8'h05);
        pulse(1'b0, 1'b1, 8'hC5);
        wr(`ADDR_BUF_LOW, 8'h03); // reload for next event
        wr(`ADDR_BUF_HIGH, 8'h60);
        pulse(1'b1, 1'b1, 8'h63);
        wr(`ADDR_CONTROL, 8'h1B);
        wr(`ADDR_BUF_LOW, 8'h09);
        pulse(1'b1, 1'b0, 8'h63);
        extFire(8'h69);
        wr(`ADDR_CONTROL, 8'h0B);
        wr(`ADDR_BUF_LOW, 8'h04);
        pulse(1'b1, 1'b0, 8'h64);
        $display("test four bit done");
    endtask

    task testEightBit();
        wr(`ADDR_CONTROL, 8'h07);
        wr(`ADDR_BUF_LOW, 8'h96);
        rd(`ADDR_BUF_HIGH, 8'h96, "byte write loads both");
        pulse(1'b0, 1'b1, 8'h64);
        pulse(1'b1, 1'b0, 8'h96);
        wr(`ADDR_BUF_HIGH, 8'h3C);
        wr(`ADDR_CONTROL, 8'h1F);
        pulse(1'b1, 1'b0, 8'h96);
        extFire(8'h3C);
        wr(`ADDR_PORT_LATCH, 8'h00);
        rd(`ADDR_PORT_LATCH, 8'h3C, "latch write refused");
        chk(seen, 8'h3C, "driver saw pattern");
        wr(`ADDR_CONTROL, 8'h05);
        wr(`ADDR_BUF_HIGH, 8'hA5);
        rd(`ADDR_BUF_LOW, 8'hAC, "byte bit without both enables");
        $display("test eight bit done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // verdict in one place
    task summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog against a hang anywhere in the sequence
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        $display("ERROR %0t run limit reached", $time);
        summarize();
    end

    // reset for three cycles, then the scenarios in turn
    initial
    begin
        fails = 0;
        compares = 0;
        nrst = 1'b0;
        sfrAddr = 8'h00;
        sfrWr = 1'b0;
        sfrBitWr = 1'b0;
        sfrBitSel = 3'h0;
        sfrBitVal = 1'b0;
        sfrWdata = 8'h00;
        sfrRd = 1'b0;
        cmp0 = 1'b0;
        cmp1 = 1'b0;
        extReq = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        testControl();
        testBuffers();
        testLatch();
        testFourBit();
        testEightBit();
        summarize();
    end
endmodule
